// ---- rtl/pmc_pkg.sv ----
// Constants, register map and types of the PID motor speed controller.
// Function
// - Run PID loop only while algorithm select equals one.
// - Decode select: 0 arms calibration, 1 PID, 2 default tuned algorithm.
// - Error equals desired speed minus measured speed.
// - Speed step maps through speed curve to desired drive setpoint.
// - Measured back-EMF stands for actual motor speed.
// - Proportional term is error times proportional gain.
// - Integral term is accumulated error over a period times integral gain.
// - Derivative term is error change rate times derivative gain.
// - Sum of three scaled terms forms corrected motor drive.
// - Loop repeats continuously while PID is selected.
// - Gains are bytes 0-255, reset to 4, 8 and 1.
package pmc_pkg;

   // ----------------------------------------------------------------
   // Register map.
   // ----------------------------------------------------------------
   localparam logic [7:0] PMC_OFS_KP = 8'h99;
   localparam logic [7:0] PMC_OFS_KI = 8'h9a;
   localparam logic [7:0] PMC_OFS_KD = 8'h9b;
   localparam logic [7:0] PMC_OFS_ALG = 8'h95;
   localparam logic [7:0] PMC_OFS_STEP = 8'ha0;
   localparam logic [7:0] PMC_OFS_DRIVE = 8'ha1;
   localparam logic [7:0] PMC_OFS_STATUS = 8'ha2;
   localparam logic [7:0] PMC_OFS_CURVE = 8'hc0;

   // ----------------------------------------------------------------
   // Reset values.
   // ----------------------------------------------------------------
   localparam logic [7:0] PMC_RST_KP = 8'h04;
   localparam logic [7:0] PMC_RST_KI = 8'h08;
   localparam logic [7:0] PMC_RST_KD = 8'h01;
   localparam logic [1:0] PMC_RST_ALG = 2'h2;

   // ----------------------------------------------------------------
   // Timing: loop update period and integral window.
   // ----------------------------------------------------------------
   localparam int PMC_CLK_HZ = 40000000;
   localparam int PMC_LOOP_US = 100;
   localparam int PMC_LOOP_CYC = PMC_CLK_HZ / 1000000 * PMC_LOOP_US;
   localparam int PMC_INT_WINDOW = 64;

   // Algorithm select codes.
   typedef enum logic [1:0] {
      PMC_ALG_CALIB = 2'b00,
      PMC_ALG_PID = 2'b01,
      PMC_ALG_TUNED = 2'b10
   } pmc_alg_t;

   // Pipeline stages of one loop update.
   typedef enum logic [1:0] {
      PMC_ST_IDLE = 2'b00,
      PMC_ST_ERR = 2'b01,
      PMC_ST_TERM = 2'b10,
      PMC_ST_SUM = 2'b11
   } pmc_state_t;

endpackage : pmc_pkg

// ---- rtl/pmc_gain_scaler.sv ----
// Signed error times unsigned byte gain.
`timescale 1ns/100ps
module pmc_gain_scaler #(
   parameter int IN_W = 18
) (
   clk_sys,
   sys_rst,
   termIn,
   gain,
   scaled
);
   input wire logic clk_sys;
   input wire logic sys_rst;
   input wire logic signed [IN_W-1:0] termIn;
   input wire logic [7:0] gain;
   output logic signed [IN_W+8:0] scaled;

   // ----------------------------------------------------------------
   // Registered product.
   // ----------------------------------------------------------------
   // Gain is widened with a zero sign bit so the product stays signed.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         scaled <= '0;
      end else begin
         scaled <= termIn * $signed({1'b0, gain});
      end
   end

endmodule : pmc_gain_scaler

// ---- rtl/pmc_pid_motor.sv ----
// PID motor speed controller with register port and speed curve.
`timescale 1ns/100ps
module pmc_pid_motor #(
   parameter int DRIVE_W = 8,
   parameter int LOOP_CYC = pmc_pkg::PMC_LOOP_CYC,
   parameter int INT_WINDOW = pmc_pkg::PMC_INT_WINDOW
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   output logic [7:0] regRdData,
   input wire logic [DRIVE_W-1:0] bemfSample,
   output logic [DRIVE_W-1:0] motorDrive,
   output logic pidActive,
   output logic calibArmed,
   output logic tunedSelected
);

   // ----------------------------------------------------------------
   // Local widths.
   // ----------------------------------------------------------------
   // The error spans minus to plus full scale; the integral holds up to
   // sixty-four full-scale errors, and the products add a byte of gain.
   localparam int EW = DRIVE_W + 2;
   localparam int IW = DRIVE_W + 8;
   localparam int PW = IW + 9;
   localparam int SW = PW + 2;
   localparam logic [DRIVE_W-1:0] DMAX = {DRIVE_W{1'b1}};

   // Elaboration check of parameters.
   if (DRIVE_W < 4 || DRIVE_W > 16 || LOOP_CYC < 4 || INT_WINDOW < 1) begin : g_chk
      $error("pmc_pid_motor: unsupported parameter values");
   end

   // ----------------------------------------------------------------
   // Registers.
   // ----------------------------------------------------------------
   logic [7:0] kpReg;
   logic [7:0] kiReg;
   logic [7:0] kdReg;
   logic [1:0] algReg;
   logic [7:0] stepReg;
   logic [DRIVE_W-1:0] curve [0:15];
   logic [DRIVE_W-1:0] bemfMeta;
   logic [DRIVE_W-1:0] bemfSync;
   logic [DRIVE_W-1:0] bemfPrev;
   logic [DRIVE_W-1:0] bemfHold;
   logic [DRIVE_W-1:0] setpointReg;
   logic signed [EW-1:0] errReg;
   logic signed [EW-1:0] errPrevReg;
   logic signed [EW-1:0] derivReg;
   logic signed [IW-1:0] integReg;
   logic [$clog2(INT_WINDOW+1)-1:0] winCnt;
   logic [$clog2(LOOP_CYC+1)-1:0] tickCnt;
   logic [DRIVE_W-1:0] driveReg;
   pmc_pkg::pmc_state_t stateReg;
   logic signed [PW-1:0] pScaled;
   logic signed [PW-1:0] iScaled;
   logic signed [PW-1:0] dScaled;
   logic signed [SW-1:0] sumNext;
   logic signed [IW-1:0] integNext;
   logic signed [IW-1:0] intMax;
   logic isPid;

   // ----------------------------------------------------------------
   // Mode select decode.
   // ----------------------------------------------------------------
   // select decode
   assign isPid = (algReg == pmc_pkg::PMC_ALG_PID);
   assign pidActive = isPid;
   assign calibArmed = (algReg == pmc_pkg::PMC_ALG_CALIB);
   assign tunedSelected = (algReg == pmc_pkg::PMC_ALG_TUNED);
   assign intMax = $signed({2'b00, DMAX, 6'h00});

   // ----------------------------------------------------------------
   // Software registers.
   // ----------------------------------------------------------------
   // Gain and mode registers written by software.
   // gain reset values
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         kpReg <= pmc_pkg::PMC_RST_KP;
         kiReg <= pmc_pkg::PMC_RST_KI;
         kdReg <= pmc_pkg::PMC_RST_KD;
         algReg <= pmc_pkg::PMC_RST_ALG;
         stepReg <= 8'h00;
      end else if (regWrStb) begin
         unique case (regAddr)
            pmc_pkg::PMC_OFS_KP: kpReg <= regWrData;
            pmc_pkg::PMC_OFS_KI: kiReg <= regWrData;
            pmc_pkg::PMC_OFS_KD: kdReg <= regWrData;
            pmc_pkg::PMC_OFS_ALG: begin
               // Codes above two are ignored.
               if (regWrData <= 8'h02) begin
                  algReg <= regWrData[1:0];
               end
            end
            pmc_pkg::PMC_OFS_STEP: stepReg <= regWrData;
            default: ;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Speed curve.
   // ----------------------------------------------------------------
   // Speed curve table: 16 points, step uses upper nibble.
   // speed curve table
   genvar gi;
   for (gi = 0; gi < 16; gi++) begin : g_curve
      always_ff @(posedge clk_sys or posedge sys_rst) begin
         if (sys_rst) begin
            curve[gi] <= DRIVE_W'(gi * (2 ** DRIVE_W - 1) / 15);
         end else if (regWrStb && regAddr == pmc_pkg::PMC_OFS_CURVE + 8'(gi)) begin
            curve[gi] <= DRIVE_W'(regWrData);
         end
      end
   end

   // ----------------------------------------------------------------
   // Register readback.
   // ----------------------------------------------------------------
   // Read data, valid one cycle after the read strobe.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         regRdData <= 8'h00;
      end else if (regRdStb) begin
         if (regAddr >= pmc_pkg::PMC_OFS_CURVE && regAddr < pmc_pkg::PMC_OFS_CURVE + 8'h10) begin
            regRdData <= 8'(curve[regAddr[3:0]]);
         end else begin
            unique case (regAddr)
               pmc_pkg::PMC_OFS_KP: regRdData <= kpReg;
               pmc_pkg::PMC_OFS_KI: regRdData <= kiReg;
               pmc_pkg::PMC_OFS_KD: regRdData <= kdReg;
               pmc_pkg::PMC_OFS_ALG: regRdData <= {6'h00, algReg};
               pmc_pkg::PMC_OFS_STEP: regRdData <= stepReg;
               pmc_pkg::PMC_OFS_DRIVE: regRdData <= 8'(driveReg);
               pmc_pkg::PMC_OFS_STATUS: regRdData <= {6'h00, stateReg};
               default: regRdData <= 8'h00;
            endcase
         end
      end else begin
         regRdData <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Back-EMF input.
   // ----------------------------------------------------------------
   // Back-EMF arrives from the sensing pins: two flip-flops, then a word is
   // taken only when two synchronised samples agree, since the bits of a
   // changing word may settle in different cycles.
   // back-EMF sync
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         bemfMeta <= '0;
         bemfSync <= '0;
         bemfPrev <= '0;
         bemfHold <= '0;
      end else begin
         bemfMeta <= bemfSample;
         bemfSync <= bemfMeta;
         bemfPrev <= bemfSync;
         if (bemfSync == bemfPrev) begin
            bemfHold <= bemfSync;
         end
      end
   end

   // ----------------------------------------------------------------
   // Loop sequencer.
   // ----------------------------------------------------------------
   // Loop tick counter and update sequencer.
   // continuous loop
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         tickCnt <= '0;
         stateReg <= pmc_pkg::PMC_ST_IDLE;
      end else begin
         tickCnt <= (tickCnt == ($bits(tickCnt))'(LOOP_CYC - 1)) ? '0 : tickCnt + 1'b1;
         unique case (stateReg)
            pmc_pkg::PMC_ST_IDLE: begin
               if (isPid && tickCnt == '0) begin
                  stateReg <= pmc_pkg::PMC_ST_ERR;
               end
            end
            pmc_pkg::PMC_ST_ERR: stateReg <= pmc_pkg::PMC_ST_TERM;
            pmc_pkg::PMC_ST_TERM: stateReg <= pmc_pkg::PMC_ST_SUM;
            pmc_pkg::PMC_ST_SUM: stateReg <= pmc_pkg::PMC_ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Error and history.
   // ----------------------------------------------------------------
   // Error, derivative and integral bookkeeping.
   // integral clamp
   always_comb begin
      integNext = integReg + IW'(errReg);
      if (integNext > intMax) begin
         integNext = intMax;
      end else if (integNext < -intMax) begin
         integNext = -intMax;
      end
   end

   // Leaving PID clears the history, so that a later return to PID does not
   // start from a stale integral; the first derivative on return is taken against an errPrevReg of zero.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         setpointReg <= '0;
         errReg <= '0;
         errPrevReg <= '0;
         derivReg <= '0;
         integReg <= '0;
         winCnt <= '0;
      end else if (!isPid) begin
         integReg <= '0;
         errPrevReg <= '0;
         derivReg <= '0;
         winCnt <= '0;
      end else if (stateReg == pmc_pkg::PMC_ST_IDLE && tickCnt == '0) begin
         setpointReg <= curve[stepReg[7:4]];
      end else if (stateReg == pmc_pkg::PMC_ST_ERR) begin
         errReg <= EW'($signed({2'b00, setpointReg})) - EW'($signed({2'b00, bemfHold}));
      end else if (stateReg == pmc_pkg::PMC_ST_TERM) begin
         derivReg <= errReg - errPrevReg;
         errPrevReg <= errReg;
         if (winCnt == ($bits(winCnt))'(INT_WINDOW - 1)) begin
            winCnt <= '0;
            integReg <= IW'(errReg);
         end else begin
            winCnt <= winCnt + 1'b1;
            integReg <= integNext;
         end
      end
   end

   // ----------------------------------------------------------------
   // Gain scalers.
   // ----------------------------------------------------------------
   // Each scaler registers its product every cycle, so in SUM the proportional
   // product holds this pass's error while the other two hold the last pass.
   // proportional scaling
   pmc_gain_scaler #(.IN_W(IW)) uScaleP (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .termIn(IW'(errReg)),
      .gain(kpReg),
      .scaled(pScaled)
   );

   pmc_gain_scaler #(.IN_W(IW)) uScaleI (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .termIn(integReg >>> 4),
      .gain(kiReg),
      .scaled(iScaled)
   );

   pmc_gain_scaler #(.IN_W(IW)) uScaleD (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .termIn(IW'(derivReg)),
      .gain(kdReg),
      .scaled(dScaled)
   );

   // ----------------------------------------------------------------
   // Summation and drive.
   // ----------------------------------------------------------------
   // The sum is divided by four so that the reset gains give a gentle drive;
   // clamping keeps an overflowing sum from reversing the drive.
   // sum of terms
   assign sumNext = (SW'(pScaled) + SW'(iScaled) + SW'(dScaled)) >>> 2;

   // Corrected drive, updated once per loop pass; zero outside PID.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         driveReg <= '0;
      end else if (!isPid) begin
         driveReg <= '0;
      end else if (stateReg == pmc_pkg::PMC_ST_SUM) begin
         if (sumNext < 0) begin
            driveReg <= '0;
         end else if (sumNext > SW'($signed({1'b0, DMAX}))) begin
            driveReg <= DMAX;
         end else begin
            driveReg <= DRIVE_W'(sumNext);
         end
      end
   end

   assign motorDrive = driveReg;

endmodule : pmc_pid_motor

// ---- testbench/pmc_pid_motor_props.sv ----
// Assertion checker watching the ports of the PID motor speed controller.
`timescale 1ns/100ps
module pmc_pid_motor_props #(
   parameter int DRIVE_W = 8
) (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWrStb,
   input wire logic regRdStb,
   input wire logic [7:0] regRdData,
   input wire logic [DRIVE_W-1:0] bemfSample,
   input wire logic [DRIVE_W-1:0] motorDrive,
   input wire logic pidActive,
   input wire logic calibArmed,
   input wire logic tunedSelected
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   logic [7:0] kpShadow_reg;

   // Shadow copy of the proportional gain, so that read data can be judged.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         kpShadow_reg <= pmc_pkg::PMC_RST_KP;
      end else if (regWrStb && regAddr == pmc_pkg::PMC_OFS_KP) begin
         kpShadow_reg <= regWrData;
      end
   end

   // -----------------------------------------------------------------
   // Assertions.
   // -----------------------------------------------------------------
   sel_onehot_a: assert property (
      $onehot({pidActive, calibArmed, tunedSelected})) else $error("select flags not one-hot");
   drive_off_a: assert property (
      !pidActive |=> motorDrive == '0) else $error("drive not zero outside PID");
   rd_idle_a: assert property (
      !regRdStb |=> regRdData == 8'h00) else $error("read data not zero when idle");
   kp_read_a: assert property (
      regRdStb && regAddr == pmc_pkg::PMC_OFS_KP |=> regRdData == $past(kpShadow_reg))
      else $error("proportional gain read wrong");
   sel_pid_a: assert property (
      regWrStb && regAddr == pmc_pkg::PMC_OFS_ALG && regWrData == 8'h01 |=> pidActive)
      else $error("PID not selected after write");
   sel_bad_a: assert property (
      regWrStb && regAddr == pmc_pkg::PMC_OFS_ALG && regWrData > 8'h02
      |=> $stable({pidActive, calibArmed, tunedSelected})) else $error("bad select taken");
   drive_cause_a: assert property (
      $changed(motorDrive) && motorDrive != '0 |-> $past(pidActive))
      else $error("drive moved without PID");
   unmapped_rd_a: assert property (
      regRdStb && regAddr == 8'h00 |=> regRdData == 8'h00) else $error("unmapped read not zero");

   // Main scenarios reached.
   cover property (pidActive && motorDrive == '1);
   cover property (calibArmed);
   cover property (regRdStb && regAddr == pmc_pkg::PMC_OFS_KP);
endmodule : pmc_pid_motor_props

// ---- testbench/pmc_motor_model.sv ----
// Behavioural motor whose back-EMF follows the drive, or is held still.
`timescale 1ns/100ps
module pmc_motor_model (
   input wire logic clk_sys,
   input wire logic sys_rst,
   input wire logic [7:0] motorDrive,
   input wire logic holdEn,
   input wire logic [7:0] holdVal,
   output logic [7:0] bemfSample
);
   logic [7:0] speed_reg;
   logic [1:0] div_reg;

   // Speed creeps one step every four cycles toward the drive level.
   always_ff @(posedge clk_sys or posedge sys_rst) begin
      if (sys_rst) begin
         speed_reg <= 8'h00;
         div_reg <= 2'h0;
      end else begin
         div_reg <= div_reg + 2'h1;
         if (holdEn) begin
            speed_reg <= holdVal;
         end else if (div_reg == 2'h3 && speed_reg < motorDrive) begin
            speed_reg <= speed_reg + 8'h01;
         end else if (div_reg == 2'h3 && speed_reg > motorDrive) begin
            speed_reg <= speed_reg - 8'h01;
         end
      end
   end
   assign bemfSample = speed_reg; // Back-EMF tracks speed.
endmodule : pmc_motor_model

// ---- testbench/pmc_pid_motor_tb_top.sv ----
// Self-checking testbench of the PID motor speed controller.
`timescale 1ns/100ps
module pmc_pid_motor_tb_top;
   localparam int LC = 8;
   logic clk_sys, sys_rst, regWrStb, regRdStb, holdEn, seen;
   logic [7:0] regAddr, regWrData, regRdData, bemfSample, motorDrive, holdVal, rdVal;
   logic pidActive, calibArmed, tunedSelected;
   int mismatches = 0;
   int total_checks = 0;

   pmc_pid_motor #(.LOOP_CYC(LC), .INT_WINDOW(4)) pmc_pid_motor_inst (.clk_sys(clk_sys),
      .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb),
      .regRdStb(regRdStb), .regRdData(regRdData), .bemfSample(bemfSample),
      .motorDrive(motorDrive), .pidActive(pidActive), .calibArmed(calibArmed),
      .tunedSelected(tunedSelected));
   pmc_motor_model pmc_motor_model_inst (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .motorDrive(motorDrive), .holdEn(holdEn), .holdVal(holdVal), .bemfSample(bemfSample));

   // Clock of 25 ns period.
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // -----------------------------------------------------------------
   // Bus and compare tasks.
   // -----------------------------------------------------------------
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regWrStb <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk_sys);
      regWrStb <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys);
      regRdStb <= 1'b1;
      regAddr <= a;
      @(posedge clk_sys);
      regRdStb <= 1'b0;
      #1 rdVal = regRdData;
   endtask : rd
   task automatic pid(input logic [7:0] kp, ki, kd, bemf, exp, input string what);
      wr(pmc_pkg::PMC_OFS_KP, kp);
      wr(pmc_pkg::PMC_OFS_KI, ki);
      wr(pmc_pkg::PMC_OFS_KD, kd);
      holdVal <= bemf;
      repeat (8 * LC) @(posedge clk_sys);
      #1 chk(what, exp, motorDrive);
   endtask : pid
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize

   // -----------------------------------------------------------------
   // Scenarios.
   // -----------------------------------------------------------------
   task automatic t_reset();
      rd(pmc_pkg::PMC_OFS_KP);
      chk("kp reset", 8'h04, rdVal);
      rd(pmc_pkg::PMC_OFS_KI);
      chk("ki reset", 8'h08, rdVal);
      rd(pmc_pkg::PMC_OFS_KD);
      chk("kd reset", 8'h01, rdVal);
      rd(8'h00);
      chk("unmapped", 8'h00, rdVal);
      chk("tuned", 8'h01, {7'h00, tunedSelected});
   endtask : t_reset
   task automatic t_regs();
      for (int i = 0; i < 3; i++) begin
         wr(pmc_pkg::PMC_OFS_KP + 8'(i), 8'hff);
         rd(pmc_pkg::PMC_OFS_KP + 8'(i));
         chk("gain top", 8'hff, rdVal);
         wr(pmc_pkg::PMC_OFS_KP + 8'(i), 8'h00);
         rd(pmc_pkg::PMC_OFS_KP + 8'(i));
         chk("gain zero", 8'h00, rdVal);
      end
   endtask : t_regs
   task automatic t_select();
      wr(pmc_pkg::PMC_OFS_ALG, 8'h00);
      #1 chk("calib", 8'h01, {7'h00, calibArmed});
      wr(pmc_pkg::PMC_OFS_ALG, 8'h03);
      #1 chk("bad select", 8'h01, {7'h00, calibArmed});
      wr(pmc_pkg::PMC_OFS_ALG, 8'h01);
      #1 chk("pid", 8'h01, {7'h00, pidActive});
   endtask : t_select
   task automatic t_loop();
      wr(pmc_pkg::PMC_OFS_CURVE + 8'h08, 8'h80);
      wr(pmc_pkg::PMC_OFS_STEP, 8'h80);
      pid(8'h04, 8'h00, 8'h00, 8'h20, 8'h60, "p term");
      rd(pmc_pkg::PMC_OFS_DRIVE);
      chk("drive readback", 8'h60, rdVal);
      rd(pmc_pkg::PMC_OFS_STEP);
      chk("step readback", 8'h80, rdVal);
      pid(8'hff, 8'h00, 8'h00, 8'h20, 8'hff, "p clamp");
      pid(8'h04, 8'h00, 8'h00, 8'hf0, 8'h00, "neg drive");
      pid(8'h00, 8'hff, 8'h00, 8'h20, 8'hff, "i term");
      pid(8'h00, 8'h00, 8'hff, 8'h20, 8'h00, "d steady");
      holdVal <= 8'h00;
      seen = 1'b0;
      repeat (6 * LC) begin
         @(posedge clk_sys);
         #1 seen |= (motorDrive === 8'hff);
      end
      chk("d kick", 8'h01, {7'h00, seen});
   endtask : t_loop
   task automatic t_run();
      logic [7:0] last;
      int changes;
      changes = 0;
      wr(pmc_pkg::PMC_OFS_KD, 8'h00);
      wr(pmc_pkg::PMC_OFS_KP, 8'h04);
      holdEn <= 1'b0;
      #1 last = motorDrive;
      repeat (40 * LC) begin
         @(posedge clk_sys);
         #1 changes += int'(motorDrive !== last);
         last = motorDrive;
      end
      chk("updates", 8'h01, {7'h00, changes > 2});
      wr(pmc_pkg::PMC_OFS_ALG, 8'h02);
      @(posedge clk_sys);
      #1 chk("drive off", 8'h00, motorDrive);
      chk("tuned back", 8'h01, {7'h00, tunedSelected});
      repeat (2) @(posedge clk_sys);
      rd(pmc_pkg::PMC_OFS_STATUS);
      chk("status idle", 8'h00, rdVal);
   endtask : t_run

   // Main sequence after a five cycle reset.
   initial begin
      sys_rst = 1'b1;
      regWrStb = 1'b0;
      regRdStb = 1'b0;
      regAddr = 8'h00;
      regWrData = 8'h00;
      holdEn = 1'b1;
      holdVal = 8'h00;
      repeat (5) @(posedge clk_sys);
      sys_rst <= 1'b0;
      t_reset();
      t_regs();
      t_select();
      t_loop();
      t_run();
      summarize();
   end

   // Watchdog cuts a hang short.
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      summarize();
   end
endmodule : pmc_pid_motor_tb_top

bind pmc_pid_motor pmc_pid_motor_props #(.DRIVE_W(DRIVE_W)) pmc_pid_motor_props_inst (
   .clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
   .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .bemfSample(bemfSample),
   .motorDrive(motorDrive), .pidActive(pidActive), .calibArmed(calibArmed),
   .tunedSelected(tunedSelected));
